// ---- rtl/motion_flags_pkg.sv ----
// constants, field layout and command codes for the motion status flags
package motion_flags_pkg;

  // system and axis counts, field widths
  localparam int NUM_SYS   = 2;
  localparam int NUM_AXES  = 8;
  localparam int FLAG_W    = 9;
  localparam int ADDR_W    = 8;
  localparam int FOVR_W    = 5;
  localparam int RATIO_W   = 8;
  localparam int INT_W     = 4;

  // flag bit positions inside one system's flag word
  localparam int FLAG_SETTLED  = 0;
  localparam int FLAG_JOG_DONE = 1;
  localparam int FLAG_RAPID    = 2;
  localparam int FLAG_FEED     = 3;
  localparam int FLAG_TAP      = 4;
  localparam int FLAG_THREAD   = 5;
  localparam int FLAG_SYNC     = 6;
  localparam int FLAG_CSS      = 7;
  localparam int FLAG_SKIP     = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_FLAGS0     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FLAGS1     = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SPDL_OVR   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SPDL_RATIO = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_INT_CLEAR  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_INT_ENABLE = 8'h18;

  // interrupt status layout: settled rise, jog done rise, per system
  localparam int INT_SETTLED0 = 0;
  localparam int INT_JOG0     = 1;
  localparam int INT_SETTLED1 = 2;
  localparam int INT_JOG1     = 3;

  // reset values
  localparam logic [RATIO_W-1:0] FULL_RATIO   = 8'h64;
  localparam logic [RATIO_W-1:0] OVR_RESET    = 8'h64;
  localparam logic [INT_W-1:0]   INT_EN_RESET = 4'h0;

  // feed override select, all low-active bits inactive means 0 %
  localparam logic [FOVR_W-1:0] FOVR_ZERO_N = 5'h1F;

  // snapshot scan period
  localparam int SCAN_PERIOD_NS = 10000;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SCAN_CYCLES    = SCAN_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SCAN_W         = 10;

  // decoded commands from the program interpreter
  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_RAPID,
    CMD_POSITION,
    CMD_REF_RETURN,
    CMD_LINEAR,
    CMD_CIRC_CW,
    CMD_CIRC_CCW,
    CMD_SKIP,
    CMD_THREAD,
    CMD_CYCLE_CANCEL,
    CMD_TAP_CYCLE,
    CMD_TAP_MODE,
    CMD_CUT_MODE,
    CMD_SYNC_FEED,
    CMD_ASYNC_FEED,
    CMD_CSS_ON
  } cmd_code_t;

  localparam int CMD_W = 4;

endpackage : motion_flags_pkg

// ---- rtl/flag_cmd_if.sv ----
// per-system controller events in, live flags out
`timescale 1ns/1ps
interface flag_cmd_if;
  import motion_flags_pkg::*;

  logic                  auto_mode;        // memory, mdi or tape
  logic                  motion_active;    // motion executing
  logic                  accel_lag;        // accel/decel delay left
  logic [NUM_AXES-1:0]   axis_moving_plus_flags;
  logic [NUM_AXES-1:0]   axis_moving_minus_flags;
  logic                  cmd_strobe;       // one-cycle command pulse
  cmd_code_t             cmd_code;         // decoded command
  logic                  css_off;          // surface speed cancel pulse
  logic                  block_done;       // block completed pulse
  logic                  pause_request_n;  // low requests pause
  logic                  interlock_stop;   // axis interlock stop
  logic [FOVR_W-1:0]     feed_override_select_n;
  logic                  stroke_end;       // hard or soft stroke end
  logic                  reset_cond;       // controller reset condition
  logic                  reset_rewind;     // reset and rewind request
  logic                  jog_start;        // random feed move start
  logic                  jog_complete;     // random feed move finished
  logic [RATIO_W-1:0]    spindle_override; // requested percent
  logic [FLAG_W-1:0]     flags;            // live flag word
  logic [RATIO_W-1:0]    spindle_ratio;    // effective percent

  modport core (
    input  auto_mode, motion_active, accel_lag, axis_moving_plus_flags,
           axis_moving_minus_flags, cmd_strobe, cmd_code, css_off,
           block_done, pause_request_n, interlock_stop,
           feed_override_select_n, stroke_end, reset_cond,
           reset_rewind, jog_start, jog_complete, spindle_override,
    output flags, spindle_ratio
  );

  modport top (
    output auto_mode, motion_active, accel_lag, axis_moving_plus_flags,
           axis_moving_minus_flags, cmd_strobe, cmd_code, css_off,
           block_done, pause_request_n, interlock_stop,
           feed_override_select_n, stroke_end, reset_cond,
           reset_rewind, jog_start, jog_complete, spindle_override,
    input  flags, spindle_ratio
  );

endinterface : flag_cmd_if

// ---- rtl/system_flag_core.sv ----
// flag logic of one controlled system
`timescale 1ns/1ps
module system_flag_core
  import motion_flags_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  flag_cmd_if.core bus
);

  logic settled;      // accel/decel settled
  logic jog_busy;     // random feed move running
  logic jog_done;     // random feed move finished
  logic rapid;        // rapid traverse
  logic feed;         // machining feed
  logic tap_cycle;    // canned tapping cycle modal
  logic tap_mode;     // tapping mode modal
  logic thread;       // threading
  logic sync_feed;    // spindle linked feed
  logic constant_surface_speed_flag;          // constant surface speed
  logic skip;         // skip running
  logic stop_any;     // any stop event
  logic cmd;          // command valid
  logic motion_cmd;   // any motion command
  logic group01;      // group 01 motion command

  // common stop events and command classes
  assign stop_any = bus.block_done | ~bus.pause_request_n
                  | bus.interlock_stop | bus.stroke_end | bus.reset_cond
                  | (bus.feed_override_select_n == FOVR_ZERO_N)
                  | ~bus.auto_mode;
  assign cmd      = bus.cmd_strobe & bus.auto_mode;
  assign group01  = bus.cmd_code inside {CMD_RAPID, CMD_LINEAR,
                    CMD_CIRC_CW, CMD_CIRC_CCW, CMD_THREAD};
  assign motion_cmd = group01 | (bus.cmd_code inside {CMD_POSITION,
                    CMD_REF_RETURN, CMD_SKIP});

  // settled: no motion, no lag, no axis moving; machine lock not gated
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      settled <= 1'b0;
    else
      settled <= ~bus.motion_active & ~bus.accel_lag
               & ~|bus.axis_moving_plus_flags
               & ~|bus.axis_moving_minus_flags;

  // random feed completion; reset and rewind aborts without done
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      jog_busy <= 1'b0;
      jog_done <= 1'b0;
    end
    else if (bus.reset_rewind)
    begin
      jog_busy <= 1'b0;
      jog_done <= 1'b0;
    end
    else if (bus.jog_start)
    begin
      jog_busy <= 1'b1;
      jog_done <= 1'b0;
    end
    else if (jog_busy && bus.jog_complete)
    begin
      jog_busy <= 1'b0;
      jog_done <= 1'b1;
    end

  // rapid traverse, auto only, machine lock not gated
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      rapid <= 1'b0;
    else if (stop_any)
      rapid <= 1'b0;
    else if (cmd)
      rapid <= bus.cmd_code inside {CMD_RAPID, CMD_POSITION,
                                    CMD_REF_RETURN};

  // machining feed, auto only
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      feed <= 1'b0;
    else if (stop_any)
      feed <= 1'b0;
    else if (cmd)
      feed <= bus.cmd_code inside {CMD_LINEAR, CMD_CIRC_CW,
                                   CMD_CIRC_CCW, CMD_SKIP};

  // tapping modals
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      tap_cycle <= 1'b0;
      tap_mode  <= 1'b0;
    end
    else if (bus.reset_cond)
    begin
      tap_cycle <= 1'b0;
      tap_mode  <= 1'b0;
    end
    else if (cmd)
    begin
      if (bus.cmd_code == CMD_TAP_CYCLE)
        tap_cycle <= 1'b1;
      else if (bus.cmd_code == CMD_CYCLE_CANCEL || group01)
        tap_cycle <= 1'b0;
      if (bus.cmd_code == CMD_TAP_MODE)
        tap_mode <= 1'b1;
      else if (bus.cmd_code == CMD_CUT_MODE)
        tap_mode <= 1'b0;
    end

  // threading, sync feed, surface speed, skip
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      thread    <= 1'b0;
      sync_feed <= 1'b0;
      constant_surface_speed_flag       <= 1'b0;
      skip      <= 1'b0;
    end
    else
    begin
      if (bus.reset_cond)
        thread <= 1'b0;
      else if (bus.cmd_strobe && motion_cmd)
        thread <= bus.cmd_code == CMD_THREAD;
      if (bus.cmd_strobe && bus.cmd_code == CMD_SYNC_FEED)
        sync_feed <= 1'b1;
      else if (bus.cmd_strobe && bus.cmd_code == CMD_ASYNC_FEED)
        sync_feed <= 1'b0;
      if (bus.cmd_strobe && bus.css_off)
        constant_surface_speed_flag <= 1'b0;
      else if (cmd && bus.cmd_code == CMD_CSS_ON)
        constant_surface_speed_flag <= 1'b1;
      if (bus.block_done || bus.reset_cond)
        skip <= 1'b0;
      else if (cmd && bus.cmd_code == CMD_SKIP)
        skip <= 1'b1;
    end

  // effective spindle ratio, forced full while threading
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      bus.spindle_ratio <= FULL_RATIO;
    else
      bus.spindle_ratio <= thread ? FULL_RATIO
                                  : bus.spindle_override;

  // assemble flag word
  always_comb
  begin
    bus.flags                = '0;
    bus.flags[FLAG_SETTLED]  = settled;
    bus.flags[FLAG_JOG_DONE] = jog_done;
    bus.flags[FLAG_RAPID]    = rapid;
    bus.flags[FLAG_FEED]     = feed;
    bus.flags[FLAG_TAP]      = (tap_cycle | tap_mode) & bus.auto_mode
                             & bus.motion_active;
    bus.flags[FLAG_THREAD]   = thread;
    bus.flags[FLAG_SYNC]     = sync_feed;
    bus.flags[FLAG_CSS]      = constant_surface_speed_flag;
    bus.flags[FLAG_SKIP]     = skip;
  end

endmodule : system_flag_core

// ---- rtl/motion_status_flags.sv ----
// motion status flags with scan snapshot, apb registers and interrupt
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - settled flag high after motion without lag
// - settled flag ignores machine lock
// - settled needs all axis moving flags low
// - jog done set on completion, held until next jog start or reset and rewind
// - reset and rewind abort leaves jog done low
// - rapid flag during automatic rapid motion
// - rapid flag cleared by stop events
// - rapid updates under lock, never manual
// - feed flag during automatic feed motion
// - feed flag cleared by stop events
// - feed updates under lock, never manual
// - tapping flag in tap cycle or mode, only in auto with motion active
// - tapping cleared by cancel or mode commands
// - threading set on thread, cleared by other motion commands or reset
// - threading forces spindle ratio to full
// - sync feed set and cleared by commands
// - surface speed set in auto, cleared
// - skip flag until its block completes
module motion_status_flags
  import motion_flags_pkg::*;
(
  // clock and reset
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  // apb slave
  input  wire logic [ADDR_W-1:0]                 paddr,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // interrupt
  output logic                                   irq,
  // controller events, one lane per system
  input  wire logic [NUM_SYS-1:0]                auto_mode,
  input  wire logic [NUM_SYS-1:0]                motion_active,
  input  wire logic [NUM_SYS-1:0]                accel_lag,
  input  wire logic [NUM_SYS-1:0][NUM_AXES-1:0]  axis_moving_plus_flags,
  input  wire logic [NUM_SYS-1:0][NUM_AXES-1:0]  axis_moving_minus_flags,
  input  wire logic [NUM_SYS-1:0]                cmd_strobe,
  input  wire logic [NUM_SYS-1:0][CMD_W-1:0]     cmd_code,
  input  wire logic [NUM_SYS-1:0]                css_off,
  input  wire logic [NUM_SYS-1:0]                block_done,
  input  wire logic [NUM_SYS-1:0]                pause_request_n,
  input  wire logic [NUM_SYS-1:0]                interlock_stop,
  input  wire logic [NUM_SYS-1:0][FOVR_W-1:0]    feed_override_select_n,
  input  wire logic [NUM_SYS-1:0]                stroke_end,
  input  wire logic [NUM_SYS-1:0]                reset_cond,
  input  wire logic [NUM_SYS-1:0]                reset_rewind,
  input  wire logic [NUM_SYS-1:0]                jog_start,
  input  wire logic [NUM_SYS-1:0]                jog_complete,
  // scan boundary marker
  output logic                                   scan_tick
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  flag_cmd_if sys_if [NUM_SYS] ();              // per-system carriers

  logic [NUM_SYS-1:0][FLAG_W-1:0]  live_flags;   // flags from the cores
  logic [NUM_SYS-1:0][RATIO_W-1:0] live_ratio;   // ratios from the cores
  logic [NUM_SYS-1:0][FLAG_W-1:0]  snap_flags;   // scan snapshot
  logic [NUM_SYS-1:0][RATIO_W-1:0] snap_ratio;   // scan snapshot ratio
  logic [NUM_SYS-1:0][FLAG_W-1:0]  prev_flags;   // previous snapshot
  logic [NUM_SYS-1:0][RATIO_W-1:0] spdl_ovr;     // software override
  logic [SCAN_W-1:0]               scan_cnt;     // scan period counter
  logic                            scan_pend;    // snapshot due next edge
  logic [INT_W-1:0]                int_status;   // sticky events
  logic [INT_W-1:0]                int_enable;   // interrupt mask
  logic [INT_W-1:0]                int_events;   // this cycle's events
  logic                            setup_ph;     // apb setup phase
  logic                            access_ph;    // apb access phase
  logic                            wr_en;        // write takes effect
  logic                            addr_ok;      // mapped address
  logic [31:0]                     next_prdata;  // read mux output

  ////////////////////////////////////////////////////////////////////////
  // per-system flag cores

  genvar s;
  generate
    for (s = 0; s < NUM_SYS; s++)
    begin : g_sys
      // drive the carrier from the top ports
      assign sys_if[s].auto_mode               = auto_mode[s];
      assign sys_if[s].motion_active           = motion_active[s];
      assign sys_if[s].accel_lag               = accel_lag[s];
      assign sys_if[s].axis_moving_plus_flags  = axis_moving_plus_flags[s];
      assign sys_if[s].axis_moving_minus_flags = axis_moving_minus_flags[s];
      assign sys_if[s].cmd_strobe              = cmd_strobe[s];
      assign sys_if[s].cmd_code                = cmd_code_t'(cmd_code[s]);
      assign sys_if[s].css_off                 = css_off[s];
      assign sys_if[s].block_done              = block_done[s];
      assign sys_if[s].pause_request_n         = pause_request_n[s];
      assign sys_if[s].interlock_stop          = interlock_stop[s];
      assign sys_if[s].feed_override_select_n  = feed_override_select_n[s];
      assign sys_if[s].stroke_end              = stroke_end[s];
      assign sys_if[s].reset_cond              = reset_cond[s];
      assign sys_if[s].reset_rewind            = reset_rewind[s];
      assign sys_if[s].jog_start               = jog_start[s];
      assign sys_if[s].jog_complete            = jog_complete[s];
      assign sys_if[s].spindle_override        = spdl_ovr[s];
      // collect results
      assign live_flags[s] = sys_if[s].flags;
      assign live_ratio[s] = sys_if[s].spindle_ratio;

      // one independent copy of every flag per system
      system_flag_core u_core (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (sys_if[s])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // scan timing

  // counts the scan period, marks its last cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      scan_cnt <= '0;
    else if (scan_pend)
      scan_cnt <= '0;
    else
      scan_cnt <= scan_cnt + 1'b1;
  end

  assign scan_pend = (scan_cnt == SCAN_W'(SCAN_CYCLES - 1));

  // one-cycle marker after each snapshot update
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      scan_tick <= 1'b0;
    else
      scan_tick <= scan_pend;
  end

  ////////////////////////////////////////////////////////////////////////
  // snapshot

  // all systems refreshed together so reads stay consistent
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      snap_flags <= '0;
      snap_ratio <= {NUM_SYS{FULL_RATIO}};
      prev_flags <= '0;
    end
    else if (scan_pend)
    begin
      snap_flags <= live_flags;
      snap_ratio <= live_ratio;
      prev_flags <= snap_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupts

  // rising edges of settled and jog done in the snapshot
  always_comb
  begin
    int_events               = '0;
    int_events[INT_SETTLED0] = snap_flags[0][FLAG_SETTLED]
                             & ~prev_flags[0][FLAG_SETTLED];
    int_events[INT_JOG0]     = snap_flags[0][FLAG_JOG_DONE]
                             & ~prev_flags[0][FLAG_JOG_DONE];
    int_events[INT_SETTLED1] = snap_flags[1][FLAG_SETTLED]
                             & ~prev_flags[1][FLAG_SETTLED];
    int_events[INT_JOG1]     = snap_flags[1][FLAG_JOG_DONE]
                             & ~prev_flags[1][FLAG_JOG_DONE];
    // edges count once, in the cycle after the snapshot moved
    if (!scan_tick)
      int_events = '0;
  end

  // sticky status; a new event wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_status <= '0;
    else if (wr_en && paddr == OFS_INT_CLEAR)
      int_status <= (int_status & ~pwdata[INT_W-1:0]) | int_events;
    else
      int_status <= int_status | int_events;
  end

  // interrupt enable register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_enable <= INT_EN_RESET;
    else if (wr_en && paddr == OFS_INT_ENABLE)
      int_enable <= pwdata[INT_W-1:0];
  end

  // level interrupt while any enabled bit is set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(int_status & int_enable);
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign pready    = 1'b1;                 // zero wait states
  assign wr_en     = access_ph & pwrite & addr_ok;

  // mapped addresses; clear is write-only, flags and status read-only
  always_comb
  begin
    unique case (paddr)
      OFS_FLAGS0, OFS_FLAGS1, OFS_SPDL_RATIO, OFS_INT_STATUS:
        addr_ok = ~pwrite;
      OFS_INT_CLEAR:
        addr_ok = pwrite;
      OFS_SPDL_OVR, OFS_INT_ENABLE:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  end

  // error answer for unmapped or wrong-direction access
  assign pslverr = access_ph & ~addr_ok;

  // spindle override per system, software written
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      spdl_ovr <= {NUM_SYS{OVR_RESET}};
    else if (wr_en && paddr == OFS_SPDL_OVR)
    begin
      spdl_ovr[0] <= pwdata[RATIO_W-1:0];
      spdl_ovr[1] <= pwdata[2*RATIO_W-1:RATIO_W];
    end
  end

  // read mux
  always_comb
  begin
    next_prdata = '0;
    unique case (paddr)
      OFS_FLAGS0:
        next_prdata[FLAG_W-1:0] = snap_flags[0];
      OFS_FLAGS1:
        next_prdata[FLAG_W-1:0] = snap_flags[1];
      OFS_SPDL_OVR:
        next_prdata[2*RATIO_W-1:0] = {spdl_ovr[1], spdl_ovr[0]};
      OFS_SPDL_RATIO:
        next_prdata[2*RATIO_W-1:0] = {snap_ratio[1], snap_ratio[0]};
      OFS_INT_STATUS:
        next_prdata[INT_W-1:0] = int_status;
      OFS_INT_ENABLE:
        next_prdata[INT_W-1:0] = int_enable;
      default:
        next_prdata = '0;
    endcase
  end

  // read data captured in setup, shown through the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (setup_ph && !pwrite)
      prdata <= next_prdata;
    else if (setup_ph)
      prdata <= '0;
  end

endmodule : motion_status_flags

// ---- testbench/motion_status_flags_assertions.sv ----
// port assertions for the motion status flags block
`timescale 1ns/1ps
module motion_status_flags_assertions
  import motion_flags_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              irq,
  input wire logic              scan_tick
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;  // access phase
  wire wr  = acc && pwrite;    // write access, mapped or not
  tick_single_a: assert property (scan_tick |=> !scan_tick)
    else $error("scan tick wider than one cycle");
  tick_gap_a: assert property (scan_tick |=> !scan_tick [*8])
    else $error("scan ticks too close");
  apb_ready_a: assert property (acc |-> pready)
    else $error("no ready in access");
  err_phase_a: assert property (pslverr |-> acc)
    else $error("error outside access");
  flags_ro_a: assert property (
    wr && paddr == OFS_FLAGS0 |-> pslverr) else $error("flag write taken");
  unmapped_error_a: assert property (
    acc && paddr == 8'hFC |-> pslverr) else $error("unmapped access taken");
  irq_rise_a: assert property ($rose(irq) |->
    $past(scan_tick, 2) || $past(wr, 2)) else $error("irq rose uncaused");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr, 2))
    else $error("irq fell without write");
  cover property (scan_tick);
  cover property ($rose(irq));
  cover property (pslverr);
endmodule : motion_status_flags_assertions

bind motion_status_flags motion_status_flags_assertions i_chk (.pclk,
  .presetn, .paddr, .psel, .penable, .pwrite, .pready, .pslverr, .irq,
  .scan_tick);

// ---- testbench/scan_program.sv ----
// sequence program model: times the snapshot scans
`timescale 1ns/1ps
module scan_program
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        scan_tick,
  output logic      [15:0] gap
);
  logic [15:0] cnt;  // cycles since last scan
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {cnt, gap} <= '0;
    else if (scan_tick)
      {cnt, gap} <= {16'h0, cnt + 16'h1};
    else
      cnt <= cnt + 16'h1;
endmodule : scan_program

// ---- testbench/motion_status_flags_bench.sv ----
// self-checking bench for the motion status flags block
`timescale 1ns/1ps
module motion_status_flags_bench;
  import motion_flags_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, irq, scan_tick, err, am = 0, mv = 0;
  logic [10:0] pv = '0;  // 0-5 stops, 6 strobe, 7 css off, 8-10 jog
  logic [15:0] ax = '0, rnd = 16'hC3CB, gap;  // seed 50123
  cmd_code_t   cc = CMD_NONE;
  int          failures = 0, checked = 0, i, e;
  wire [1:0] auto_mode = {1'b0, am}, motion_active = {2{mv}}, accel_lag = '0,
    cmd_strobe = {2{pv[6]}}, block_done = {2{pv[0]}},
    pause_request_n = {2{!pv[1]}}, interlock_stop = {2{pv[2]}},
    stroke_end = {2{pv[4]}}, reset_cond = {2{pv[5]}}, css_off = {2{pv[7]}},
    jog_start = {2{pv[8]}}, reset_rewind = {2{pv[9]}},
    jog_complete = {2{pv[10]}};
  wire [1:0][7:0] axis_moving_plus_flags = {2{ax[7:0]}},
    axis_moving_minus_flags = {2{ax[15:8]}};
  wire [1:0][3:0] cmd_code = {2{cc}};
  wire [1:0][4:0] feed_override_select_n = {2{pv[3] ? FOVR_ZERO_N : 5'h0E}};
  motion_status_flags i_motion_status_flags (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq, .auto_mode,
    .motion_active, .accel_lag, .axis_moving_plus_flags,
    .axis_moving_minus_flags, .cmd_strobe, .cmd_code, .css_off, .block_done,
    .pause_request_n, .interlock_stop, .feed_override_select_n, .stroke_end,
    .reset_cond, .reset_rewind, .jog_start, .jog_complete, .scan_tick);
  scan_program i_scan_program (.pclk, .presetn, .scan_tick, .gap);
  initial forever #5 pclk = !pclk;
  function automatic logic [31:0] fbit(int b, logic v);
    return {31'h0, v} << b;
  endfunction : fbit
  function automatic logic [15:0] lfsr(logic [15:0] r);
    return {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
  endfunction : lfsr
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    checked++;
    if (g !== x)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int k;
    @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
    chk("ready wait", 0, k >= 20);
    if (k >= 20) print_verdict();
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic pulse(logic [10:0] v, cmd_code_t c);
    @(posedge pclk) {pv, cc} <= {v, c};
    @(posedge pclk) pv <= '0;
  endtask : pulse
  task automatic look(int s, int b, logic v);
    int k;
    repeat (3) @(posedge pclk);
    do @(negedge pclk); while (scan_tick !== 1'b1 && ++k < 1100);
    chk("tick wait", 0, k >= 1100);
    if (k >= 1100) print_verdict();
    apb(0, s ? OFS_FLAGS1 : OFS_FLAGS0, '0);
    chk("flag", fbit(b, v), rd & fbit(b, 1'b1));
  endtask : look
  task automatic print_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFS_SPDL_OVR, '0);
    chk("override", 32'h6464, rd);
    apb(0, OFS_INT_CLEAR, '0);
    chk("read error", 1, err);
    apb(1, OFS_FLAGS0, '1);
    chk("write error", 1, err);
    apb(0, 8'hFC, '0);
    chk("unmapped error", 1, err);
    look(0, FLAG_SETTLED, 1);
    rnd = lfsr(rnd);
    ax <= 16'h1 << rnd[3:0];
    look(0, FLAG_SETTLED, 0);
    {am, mv, ax} <= {2'b11, 16'h0};
    look(0, FLAG_SETTLED, 0);
    for (i = 0; i < 2; i++)
      for (e = 0; e < 6; e++)
      begin
        pulse(11'h040, i ? CMD_LINEAR : CMD_RAPID);
        look(0, FLAG_RAPID + i, 1);
        look(1, FLAG_RAPID + i, 0);
        pulse(11'h1 << e, CMD_NONE);
        look(0, FLAG_RAPID + i, 0);
      end
    apb(1, OFS_SPDL_OVR, {25'h0, rnd[6:0]});
    pulse(11'h040, CMD_THREAD);
    look(0, FLAG_THREAD, 1);
    apb(0, OFS_SPDL_RATIO, '0);
    chk("ratio", {24'h0, FULL_RATIO}, rd & 32'hFF);
    pulse(11'h040, CMD_LINEAR);
    look(0, FLAG_THREAD, 0);
    pulse(11'h040, CMD_SYNC_FEED);
    look(0, FLAG_SYNC, 1);
    pulse(11'h040, CMD_ASYNC_FEED);
    look(0, FLAG_SYNC, 0);
    pulse(11'h040, CMD_CSS_ON);
    look(0, FLAG_CSS, 1);
    pulse(11'h0C0, CMD_NONE);
    look(0, FLAG_CSS, 0);
    pulse(11'h040, CMD_SKIP);
    look(0, FLAG_SKIP, 1);
    pulse(11'h001, CMD_NONE);
    look(0, FLAG_SKIP, 0);
    pulse(11'h040, CMD_TAP_CYCLE);
    look(0, FLAG_TAP, 1);
    pulse(11'h040, CMD_CYCLE_CANCEL);
    look(0, FLAG_TAP, 0);
    pulse(11'h040, CMD_TAP_MODE);
    look(0, FLAG_TAP, 1);
    pulse(11'h040, CMD_CUT_MODE);
    look(0, FLAG_TAP, 0);
    {am, mv} <= 2'b00;
    apb(1, OFS_INT_ENABLE, 32'h2);
    pulse(11'h100, CMD_NONE);
    pulse(11'h400, CMD_NONE);
    look(0, FLAG_JOG_DONE, 1);
    repeat (3) @(negedge pclk);
    chk("irq", 1, irq);
    apb(1, OFS_INT_CLEAR, 32'h2);
    repeat (2) @(negedge pclk);
    chk("irq clear", 0, irq);
    pulse(11'h100, CMD_NONE);
    pulse(11'h200, CMD_NONE);
    pulse(11'h400, CMD_NONE);
    look(0, FLAG_JOG_DONE, 0);
    chk("scan gap", SCAN_CYCLES, {16'h0, gap});
    print_verdict();
  end
endmodule : motion_status_flags_bench
